// ==== rtl/ccps_pkg.sv ====
// Package of constants and types for the character code peak select block
package ccps_pkg;
  // ===========================================
  // Register map (byte addresses)
  localparam logic [7:0] CCPS_CTRL_OFF = 8'h00;
  localparam logic [7:0] CCPS_PEAKREF_OFF = 8'h04;
  localparam logic [7:0] CCPS_STATUS_OFF = 8'h08;
  localparam logic [7:0] CCPS_CHAROUT_OFF = 8'h0C;
  localparam logic [7:0] CCPS_VOLTOUT_OFF = 8'h10;
  localparam logic [7:0] CCPS_SYMBOL_OFF = 8'h14;
  // ===========================================
  // Field positions
  localparam int CCPS_CTRL_OSC_LSB = 0;
  localparam int CCPS_CTRL_ENABLE_BIT = 2;
  localparam int CCPS_CTRL_MINV_LSB = 4;
  localparam int CCPS_SYM_PEND_BIT = 8;
  // ===========================================
  // Reset values
  localparam logic [31:0] CCPS_CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] CCPS_PEAKREF_RESET = 4'h0;
  // ===========================================
  // Timing
  localparam int CCPS_CLK_MHZ = 100;
  localparam int CCPS_T8_NS = 125;
  localparam int CCPS_T4_NS = 250;
  localparam int CCPS_T8_CYC = (CCPS_T8_NS * CCPS_CLK_MHZ + 999) / 1000;
  localparam int CCPS_T4_CYC = (CCPS_T4_NS * CCPS_CLK_MHZ + 999) / 1000;
  localparam int CCPS_PEAK_SHIFTS = 3;
  localparam int CCPS_FIFO_DEPTH = 3;
  // ===========================================
  // Oscillator selection
  typedef enum logic [1:0] {
    CCPS_OSC_SIZE1,
    CCPS_OSC_SIZE4,
    CCPS_OSC_HAND,
    CCPS_OSC_SPARE
  } ccps_osc_type;
  // Candidate pair from the encoder
  typedef struct packed {
    logic [6:0] charCode;
    logic [3:0] voltCode;
  } ccps_pair_type;
endpackage

// ==== rtl/char_code_peak_select.sv ====
// Character code peak select: best match, peak, double, reject and output FIFOs
//
// Contract
// RULE_01 - Each image shift takes one 7-bit character and 4-bit voltage code.
// RULE_02 - Best voltage and character codes clear at every cycle start.
// RULE_03 - New voltage above best by one count replaces best pair; the code replaces it whenever the new voltage is greater by any amount.
// RULE_04 - Otherwise best voltage and character codes hold unchanged.
// RULE_05 - At cycle end the best pair enters character and voltage FIFOs.
// RULE_06 - Peak signal raised when new voltage exceeds controller peak reference.
// RULE_07 - Greater-or-equal and equal flags compare new and best voltage.
// RULE_08 - Character peak after all three conditions hold three column shifts.
// RULE_09 - Character match and mismatch flags compare new and best codes.
// RULE_10 - Mismatch with greater-or-equal issues transfer loading new pair; the code loads it only when the new voltage is strictly greater.
// RULE_11 - Codes differing at equal voltage give reject at next transfer.
// RULE_12 - Failing minimum standards over the cycle outputs reject code.
// RULE_13 - Code with first peak loads into first of three stages.
// RULE_14 - Each transfer strobe loads next code; codes ripple toward output.
// RULE_15 - Codes leave on strobes only with peak, code, no symbol pending.
// RULE_16 - Pending special symbol blocks character and goes through instead.
// RULE_17 - Voltage FIFO mirrors character FIFO for diagnostics only.
// RULE_18 - Software selects one of three oscillators; device clocks from it.
// RULE_19 - Eight-phase ring gives eight 125 ns pulses per vertical shift.
// RULE_20 - Four-phase generator gives four 250 ns pulses per vertical shift.
// RULE_21 - First field mark suppresses topless and bottomless flags.
// RULE_22 - Reject code and acceptance thresholds are design parameters.
`timescale 1ns/1ps
`default_nettype none
module char_code_peak_select
  import ccps_pkg::*;
#(
  parameter logic [6:0] REJECT_CODE = 7'h7F,
  parameter logic [3:0] MIN_VOLT = 4'h1,
  parameter int DEPTH = CCPS_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shiftIn,
  input wire ccps_pair_type newPair,
  input wire logic cycleStart,
  input wire logic cycleEnd,
  input wire logic [2:0] oscTick,
  input wire logic fieldMarkOne,
  input wire logic toplessIn,
  input wire logic bottomlessIn,
  input wire logic transferStrobeOne,
  input wire logic transferStrobeTwo,
  input wire logic transferStrobeThree,
  output logic characterPeak,
  output logic peakAboveRef,
  output logic [6:0] outCharCode,
  output logic [3:0] outVoltCode,
  output logic outValid,
  output logic [7:0] eightPhasePulses,
  output logic [3:0] fourPhasePulses,
  output logic toplessOut,
  output logic bottomlessOut
);
  // ===========================================
  // Synchronisers for pin inputs
  logic [2:0] oscMeta, oscSync, oscPrev;
  logic fmMeta, fmSync, tpMeta, tpSync, btMeta, btSync;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oscMeta <= 3'h0;
      oscSync <= 3'h0;
      oscPrev <= 3'h0;
      fmMeta <= 1'b0;
      fmSync <= 1'b0;
      tpMeta <= 1'b0;
      tpSync <= 1'b0;
      btMeta <= 1'b0;
      btSync <= 1'b0;
    end else begin
      oscMeta <= oscTick;
      oscSync <= oscMeta;
      oscPrev <= oscSync;
      fmMeta <= fieldMarkOne;
      fmSync <= fmMeta;
      tpMeta <= toplessIn;
      tpSync <= tpMeta;
      btMeta <= bottomlessIn;
      btSync <= btMeta;
    end
  end

  // ===========================================
  // Registers
  logic [31:0] ctrlReg;
  logic [3:0] peakReference;
  logic [7:0] symbolCode;
  logic symbolPending;
  logic apbWrite, apbRead;
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;
  logic [1:0] oscSel;
  assign oscSel = ctrlReg[CCPS_CTRL_OSC_LSB +: 2];
  logic symbolTaken;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlReg <= CCPS_CTRL_RESET;
      peakReference <= CCPS_PEAKREF_RESET;
    end else if (apbWrite) begin
      if (paddr == CCPS_CTRL_OFF)
        ctrlReg <= pwdata;
      if (paddr == CCPS_PEAKREF_OFF)
        peakReference <= pwdata[3:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      symbolCode <= 8'h00;
      symbolPending <= 1'b0;
    end else if (apbWrite && paddr == CCPS_SYMBOL_OFF) begin
      symbolCode <= pwdata[7:0];
      symbolPending <= pwdata[CCPS_SYM_PEND_BIT];
    end else if (symbolTaken) begin
      symbolPending <= 1'b0;
    end
  end

  // ===========================================
  // Oscillator select and phase generators
  logic oscEdge;
  assign oscEdge = oscSync[oscSel] && !oscPrev[oscSel] && (oscSel != 2'(CCPS_OSC_SPARE)); // RULE_18
  logic [1:0] halfTick;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eightPhasePulses <= 8'h01;
      fourPhasePulses <= 4'h1;
      halfTick <= 2'h0;
    end else if (oscEdge && ctrlReg[CCPS_CTRL_ENABLE_BIT]) begin
      eightPhasePulses <= {eightPhasePulses[6:0], eightPhasePulses[7]}; // RULE_19
      halfTick <= halfTick + 2'h1;
      if (halfTick[0])
        fourPhasePulses <= {fourPhasePulses[2:0], fourPhasePulses[3]}; // RULE_20
    end
  end

  // ===========================================
  // Comparators and best registers
  logic [3:0] bestVoltCode;
  logic [6:0] bestCharCode;
  logic voltGe, voltEq, charMatch, charMismatch, aboveRef, transferCmd;
  assign voltGe = newPair.voltCode >= bestVoltCode; // RULE_07
  assign voltEq = newPair.voltCode == bestVoltCode; // RULE_07
  assign charMatch = newPair.charCode == bestCharCode; // RULE_09
  assign charMismatch = !charMatch; // RULE_09
  assign aboveRef = newPair.voltCode > peakReference; // RULE_06
  assign transferCmd = shiftIn && charMismatch && voltGe; // RULE_10
  logic doublePending, doubleFlag;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bestVoltCode <= 4'h0;
      bestCharCode <= 7'h00;
    end else if (cycleStart) begin
      bestVoltCode <= 4'h0; // RULE_02
      bestCharCode <= 7'h00;
    end else if (shiftIn && (newPair.voltCode > bestVoltCode || transferCmd && !voltEq)) begin
      bestVoltCode <= newPair.voltCode; // RULE_01 RULE_03 RULE_10
      bestCharCode <= newPair.charCode;
    end // RULE_04
  end

  // Double detect: armed on mismatch at equal voltage, latched at next transfer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      doublePending <= 1'b0;
      doubleFlag <= 1'b0;
    end else if (cycleStart) begin
      doublePending <= 1'b0;
      doubleFlag <= 1'b0;
    end else if (shiftIn) begin
      if (transferCmd && doublePending)
        doubleFlag <= 1'b1; // RULE_11
      if (charMismatch && voltEq && bestVoltCode != 4'h0)
        doublePending <= 1'b1; // RULE_11
    end
  end

  // ===========================================
  // Peak detection over consecutive shifts
  logic [1:0] peakRun;
  logic peakCond;
  assign peakCond = aboveRef && voltGe && voltEq;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peakRun <= 2'h0;
      characterPeak <= 1'b0;
      peakAboveRef <= 1'b0;
    end else if (cycleStart) begin
      peakRun <= 2'h0;
      characterPeak <= 1'b0;
      peakAboveRef <= 1'b0;
    end else if (shiftIn) begin
      peakAboveRef <= aboveRef; // RULE_06
      if (!peakCond)
        peakRun <= 2'h0;
      else if (peakRun != 2'(CCPS_PEAK_SHIFTS))
        peakRun <= peakRun + 2'h1;
      if (peakCond && peakRun >= 2'(CCPS_PEAK_SHIFTS - 1))
        characterPeak <= 1'b1; // RULE_08
    end
  end

  // ===========================================
  // Output FIFOs (character and diagnostic voltage)
  logic [6:0] charStage [DEPTH];
  logic [3:0] voltStage [DEPTH];
  logic [DEPTH-1:0] stageFull;
  logic [6:0] entryChar;
  logic entryLoad, anyStrobe;
  logic peakSeen;
  assign anyStrobe = transferStrobeOne || transferStrobeTwo || transferStrobeThree; // RULE_14
  always_comb begin
    entryChar = bestCharCode;
    if (doubleFlag || bestVoltCode < MIN_VOLT)
      entryChar = REJECT_CODE; // RULE_12 RULE_22
    if (symbolPending)
      entryChar = symbolCode[6:0]; // RULE_16
  end
  assign entryLoad = cycleEnd && (symbolPending || peakSeen); // RULE_05 RULE_13 RULE_15
  assign symbolTaken = entryLoad && symbolPending;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      peakSeen <= 1'b0;
    else if (cycleStart)
      peakSeen <= 1'b0;
    else if (characterPeak)
      peakSeen <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stageFull <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        charStage[i] <= 7'h00;
        voltStage[i] <= 4'h0;
      end
    end else begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        if (stageFull[i-1] && (!stageFull[i] || (i == DEPTH - 1 && anyStrobe))) begin
          charStage[i] <= charStage[i-1]; // RULE_14
          voltStage[i] <= voltStage[i-1]; // RULE_17
          stageFull[i] <= 1'b1;
          stageFull[i-1] <= 1'b0;
        end else if (i == DEPTH - 1 && anyStrobe && stageFull[i]) begin
          stageFull[i] <= 1'b0; // RULE_15
        end
      end
      if (entryLoad && !stageFull[0]) begin
        charStage[0] <= entryChar; // RULE_13
        voltStage[0] <= symbolPending ? 4'h0 : bestVoltCode; // RULE_17
        stageFull[0] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outCharCode <= 7'h00;
      outVoltCode <= 4'h0;
      outValid <= 1'b0;
    end else begin
      outValid <= anyStrobe && stageFull[DEPTH-1]; // RULE_15
      if (anyStrobe && stageFull[DEPTH-1]) begin
        outCharCode <= charStage[DEPTH-1];
        outVoltCode <= voltStage[DEPTH-1]; // RULE_17
      end
    end
  end

  // ===========================================
  // Topless and bottomless gating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      toplessOut <= 1'b0;
      bottomlessOut <= 1'b0;
    end else begin
      toplessOut <= tpSync && !fmSync; // RULE_21
      bottomlessOut <= btSync && !fmSync; // RULE_21
    end
  end

  // ===========================================
  // APB read and answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          CCPS_CTRL_OFF: prdata <= ctrlReg;
          CCPS_PEAKREF_OFF: prdata <= {28'h0, peakReference};
          CCPS_STATUS_OFF: prdata <= {24'h0, stageFull[DEPTH-1], peakSeen, doubleFlag, characterPeak, bestVoltCode};
          CCPS_CHAROUT_OFF: prdata <= {25'h0, bestCharCode};
          CCPS_VOLTOUT_OFF: prdata <= {28'h0, bestVoltCode};
          CCPS_SYMBOL_OFF: prdata <= {23'h0, symbolPending, symbolCode};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel && !penable)
        pslverr <= !(paddr == CCPS_CTRL_OFF || paddr == CCPS_PEAKREF_OFF || paddr == CCPS_SYMBOL_OFF);
    end
  end

  // ===========================================
  // Assertions
  best_clear_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    cycleStart |=> bestVoltCode == 4'h0) else $error("best not cleared");
  best_load_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    !cycleStart && shiftIn && newPair.voltCode > bestVoltCode |=> bestVoltCode == $past(newPair.voltCode))
    else $error("best not loaded");
  best_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    !cycleStart && !(shiftIn && newPair.voltCode > bestVoltCode) |=> $stable(bestCharCode)
    && $stable(bestVoltCode)) else $error("best changed");
  peak_three_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
    $rose(characterPeak) |-> $past(peakCond) && $past(peakRun) == 2'h2) else $error("early peak");
  ref_flag_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    shiftIn && !cycleStart |=> peakAboveRef == ($past(newPair.voltCode) > $past(peakReference)))
    else $error("peak ref flag wrong");
  fm_gate_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_21
    fmSync |=> !toplessOut && !bottomlessOut) else $error("flags not gated");
  symbol_take_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_16
    symbolTaken && !stageFull[0] && !(apbWrite && paddr == CCPS_SYMBOL_OFF) |=> !symbolPending
    && charStage[0] == $past(symbolCode[6:0])) else $error("symbol not sent");
  out_valid_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    outValid |-> $past(anyStrobe)) else $error("output without strobe");
  double_reject_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
    entryLoad && !symbolPending && doubleFlag |-> entryChar == REJECT_CODE) else $error("no reject");
  phase_ring_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_19
    $onehot(eightPhasePulses) && $onehot(fourPhasePulses)) else $error("phase not one-hot");
  peak_c: cover property (@(posedge core_clk) disable iff (rst) $rose(characterPeak));
  double_c: cover property (@(posedge core_clk) disable iff (rst) $rose(doubleFlag));
  out_c: cover property (@(posedge core_clk) disable iff (rst) outValid);
  sym_c: cover property (@(posedge core_clk) disable iff (rst) symbolTaken);
endmodule // char_code_peak_select
`default_nettype wire

// ==== dv/ccps_bc_model.sv ====
// Buffer controller model issuing the three transfer strobes
`timescale 1ns/1ps
`default_nettype none
module ccps_buffer_ctl_model
  import ccps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  output logic transferStrobeOne,
  output logic transferStrobeTwo,
  output logic transferStrobeThree
);
  // ===========================================
  // Strobe pacing
  logic [2:0] gapCount;
  logic [1:0] strobeSel;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gapCount <= 3'h0;
      strobeSel <= 2'h0;
    end else begin
      gapCount <= gapCount + 3'h1;
      if (gapCount == 3'h7 && !stall) begin
        strobeSel <= (strobeSel == 2'h2) ? 2'h0 : strobeSel + 2'h1;
      end
    end
  end
  // ===========================================
  // One strobe every eight cycles, rotating, none while stalled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {transferStrobeThree, transferStrobeTwo, transferStrobeOne} <= 3'h0;
    end else begin
      {transferStrobeThree, transferStrobeTwo, transferStrobeOne} <= (gapCount == 3'h7 && !stall) ? (3'h1 << strobeSel) : 3'h0;
    end
  end
endmodule // ccps_buffer_ctl_model
`default_nettype wire

// ==== dv/test_char_code_peak_select.sv ====
// Self-checking bench for the character code peak select block
`timescale 1ns/1ps
`default_nettype none
module test_char_code_peak_select
  import ccps_pkg::*;
;
  localparam logic [6:0] REJECT_CODE = 7'h7F;
  localparam logic [3:0] MIN_VOLT = 4'h8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, characterPeak, peakAboveRef, outValid, toplessOut, bottomlessOut;
  logic shiftIn = 1'b0, cycleStart = 1'b0, cycleEnd = 1'b0, stall = 1'b0;
  ccps_pair_type newPair = '0;
  logic [2:0] oscTick = 3'h0;
  logic fieldMarkOne = 1'b0, toplessIn = 1'b0, bottomlessIn = 1'b0;
  logic strobeOne, strobeTwo, strobeThree;
  logic [6:0] outCharCode;
  logic [3:0] outVoltCode, fourPhasePulses, fourExp, bv;
  logic [7:0] eightPhasePulses, eightExp, rnd = 8'h46;
  logic [6:0] bestChar, c;
  logic [31:0] rdata;
  logic [10:0] expQ[$];
  int fails = 0, samplesChecked = 0;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  char_code_peak_select #(.REJECT_CODE(REJECT_CODE), .MIN_VOLT(MIN_VOLT)) dut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shiftIn(shiftIn), .newPair(newPair), .cycleStart(cycleStart),
    .cycleEnd(cycleEnd), .oscTick(oscTick), .fieldMarkOne(fieldMarkOne), .toplessIn(toplessIn),
    .bottomlessIn(bottomlessIn), .transferStrobeOne(strobeOne), .transferStrobeTwo(strobeTwo),
    .transferStrobeThree(strobeThree), .characterPeak(characterPeak), .peakAboveRef(peakAboveRef),
    .outCharCode(outCharCode), .outVoltCode(outVoltCode), .outValid(outValid),
    .eightPhasePulses(eightPhasePulses), .fourPhasePulses(fourPhasePulses), .toplessOut(toplessOut),
    .bottomlessOut(bottomlessOut));
  ccps_buffer_ctl_model partner (.core_clk(core_clk), .rst(rst), .stall(stall), .transferStrobeOne(strobeOne),
    .transferStrobeTwo(strobeTwo), .transferStrobeThree(strobeThree));
  // ===========================================
  // Helpers
  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic expErr);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    check("apb error flag", {31'h0, expErr}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic regRead(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, addr, 32'h0, 1'b0);
    check("register read", exp, rdata & mask);
  endtask
  task automatic shift(input logic [6:0] ch, input logic [3:0] v, input int n);
    repeat (n) begin
      shiftIn <= 1'b1;
      newPair <= {ch, v};
      @(posedge core_clk);
      shiftIn <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  task automatic pulseCtl(input bit isEnd, input bit push, input logic [10:0] exp);
    if (push) expQ.push_back(exp);
    if (isEnd) cycleEnd <= 1'b1;
    else cycleStart <= 1'b1;
    @(posedge core_clk);
    cycleEnd <= 1'b0;
    cycleStart <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic oscPulses(input int idx, input int n);
    repeat (n) begin
      oscTick[idx] <= 1'b1;
      repeat (6) @(posedge core_clk);
      oscTick[idx] <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ===========================================
  // Output watcher
  always @(posedge core_clk) begin
    if (outValid === 1'b1) begin
      if (expQ.size() == 0) check("spare fifo entry", 32'h0, {21'h0, outCharCode, outVoltCode});
      else check("fifo entry", {21'h0, expQ.pop_front()}, {21'h0, outCharCode, outVoltCode});
    end
  end
  initial begin
    #300000;
    fails++;
    printVerdict();
  end
  // ===========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check("eight phase reset", 32'h01, {24'h0, eightPhasePulses});
    regRead(CCPS_CTRL_OFF, CCPS_CTRL_RESET, 32'hFFFFFFFF);
    regRead(CCPS_PEAKREF_OFF, {28'h0, CCPS_PEAKREF_RESET}, 32'hFFFFFFFF);
    apb(1'b0, 8'h18, 32'h0, 1'b1);
    apb(1'b1, CCPS_STATUS_OFF, 32'hFF, 1'b1);
    // Phase generators: disabled, wrong source, right source
    eightExp = 8'h01;
    fourExp = 4'h1;
    oscPulses(0, 4);
    check("eight phase idle", {24'h0, eightExp}, {24'h0, eightPhasePulses});
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, CCPS_CTRL_OFF, 32'h4 | s, 1'b0);
      oscPulses((s + 1) % 3, 4);
      check("eight phase other source", {24'h0, eightExp}, {24'h0, eightPhasePulses});
      oscPulses(s, 4);
      eightExp = {eightExp[3:0], eightExp[7:4]};
      fourExp = {fourExp[1:0], fourExp[3:2]};
      check("eight phase ring", {24'h0, eightExp}, {24'h0, eightPhasePulses});
      check("four phase ring", {28'h0, fourExp}, {28'h0, fourPhasePulses});
    end
    regRead(CCPS_CTRL_OFF, 32'h6, 32'h7);
    // Random candidates, best tracking
    pulseCtl(1'b0, 1'b0, 11'h0);
    regRead(CCPS_VOLTOUT_OFF, 32'h0, 32'hF);
    bv = 4'h0;
    bestChar = 7'h00;
    repeat (8) begin
      rnd = nextRand(rnd);
      c = rnd[6:0];
      rnd = nextRand(rnd);
      shift(c, rnd[3:0], 1);
      if (rnd[3:0] > bv) {bestChar, bv} = {c, rnd[3:0]};
    end
    regRead(CCPS_CHAROUT_OFF, {25'h0, bestChar}, 32'h7F);
    regRead(CCPS_VOLTOUT_OFF, {28'h0, bv}, 32'hF);
    // Peak after three equal shifts above the reference
    apb(1'b1, CCPS_PEAKREF_OFF, 32'h5, 1'b0);
    pulseCtl(1'b0, 1'b0, 11'h0);
    shift(7'h41, 4'h9, 3);
    check("early peak", 32'h0, {31'h0, characterPeak});
    shift(7'h41, 4'h9, 1);
    check("character peak", 32'h1, {31'h0, characterPeak});
    check("above reference", 32'h1, {31'h0, peakAboveRef});
    shift(7'h41, 4'h5, 1);
    check("at reference", 32'h0, {31'h0, peakAboveRef});
    regRead(CCPS_STATUS_OFF, 32'h59, 32'h7F);
    pulseCtl(1'b1, 1'b1, {7'h41, 4'h9});
    // Double: equal voltage with other code, then a transfer
    pulseCtl(1'b0, 1'b0, 11'h0);
    shift(7'h41, 4'h9, 1);
    shift(7'h42, 4'h9, 1);
    shift(7'h43, 4'hC, 4);
    regRead(CCPS_STATUS_OFF, 32'h7C, 32'h7F);
    pulseCtl(1'b1, 1'b1, {REJECT_CODE, 4'hC});
    // Peak below the acceptance minimum
    apb(1'b1, CCPS_PEAKREF_OFF, 32'h2, 1'b0);
    pulseCtl(1'b0, 1'b0, 11'h0);
    shift(7'h44, MIN_VOLT - 4'h2, 4);
    pulseCtl(1'b1, 1'b1, {REJECT_CODE, MIN_VOLT - 4'h2});
    // Symbol overrides a peaked character
    apb(1'b1, CCPS_SYMBOL_OFF, 32'h12A, 1'b0);
    pulseCtl(1'b0, 1'b0, 11'h0);
    shift(7'h45, 4'hD, 4);
    pulseCtl(1'b1, 1'b1, {7'h2A, 4'h0});
    regRead(CCPS_SYMBOL_OFF, 32'h02A, 32'h1FF);
    // Fill the stages while the controller stalls
    for (int i = 0; i < 40 && expQ.size() != 0; i++) @(posedge core_clk);
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rnd = nextRand(rnd);
      apb(1'b1, CCPS_SYMBOL_OFF, {23'h0, 1'b1, 1'b0, rnd[6:0]}, 1'b0);
      pulseCtl(1'b1, k < 3, {rnd[6:0], 4'h0});
    end
    apb(1'b1, CCPS_SYMBOL_OFF, 32'h0, 1'b0);
    repeat (20) @(posedge core_clk);
    check("held entries", 32'h3, 32'(expQ.size()));
    stall <= 1'b0;
    for (int i = 0; i < 200 && expQ.size() != 0; i++) @(posedge core_clk);
    check("drained entries", 32'h0, 32'(expQ.size()));
    // Topless and bottomless suppression
    repeat (8) begin
      rnd = nextRand(rnd);
      fieldMarkOne <= rnd[0];
      toplessIn <= rnd[1];
      bottomlessIn <= rnd[2];
      repeat (5) @(posedge core_clk);
      check("topless", {31'h0, rnd[1] & ~rnd[0]}, {31'h0, toplessOut});
      check("bottomless", {31'h0, rnd[2] & ~rnd[0]}, {31'h0, bottomlessOut});
    end
    printVerdict();
  end
endmodule // test_char_code_peak_select
`default_nettype wire
